// file: smbus_cfg_target.sv
// target end: receives indexed block writes into a 16-byte config array
// assumes link clock made by the host, held high outside frames, no clock stretching
`timescale 1ns/100ps
`default_nettype none
module smbus_cfg_target #(
	parameter logic [6:0] TARGET_ADDR_BASE = 7'h50
) (
	input  wire logic                         clk_in,
	input  wire logic                         arst_n_in,
	input  wire logic                         address_select_strap_in,
	smbus_link_if.device                      link,
	output var  logic [1:0]                   ref_edge_rate_out,
	output var  logic [smbus_blk_pkg::BYTE_W-1:0] ref_cfg_out,
	output var  logic                         cfg_write_out,
	output var  logic                         busy_out
);
	import smbus_blk_pkg::*;

	typedef enum logic [9:0] {
		S_IDLE      = 10'h001,
		S_ADDR      = 10'h002,
		S_ACK_ADDR  = 10'h004,
		S_INDEX     = 10'h008,
		S_ACK_INDEX = 10'h010,
		S_COUNT     = 10'h020,
		S_ACK_COUNT = 10'h040,
		S_DATA      = 10'h080,
		S_ACK_DATA  = 10'h100,
		S_IGNORE    = 10'h200
	} rx_state_t;

	// system clock domain, plus the start and stop toggles clocked on data edges
	logic             strap_m_q;
	logic             strap_s_q;
	logic [1:0]       rst_dly_q;
	logic             strap_done_q;
	logic             strap_lat_q;
	logic [2:0]       evt_m_q;
	logic [2:0]       evt_s_q;
	logic [2:0]       evt_d_q;
	logic             start_tog_q;
	logic             stop_tog_q;
	// link clock domain
	logic             sel_m_q;
	logic             sel_s_q;
	logic             rx_bit_q;
	logic             start_seen_q;
	rx_state_t        state_q;
	logic [2:0]       bit_cnt_q;
	logic [BYTE_W-2:0] shift_q;
	logic [PTR_W-1:0] ptr_q;
	logic [BYTE_W-1:0] remain_q;
	logic             sda_oe_q;
	logic             wr_tog_q;
	logic [BYTE_W-1:0] cfg_mem [CFG_DEPTH];

	logic [BYTE_W-1:0] rx_byte;
	logic [ADDR_W-1:0] target_addr;
	logic              new_frame;
	logic              byte_end;
	logic [2:0]        evt_edge;

	assign rx_byte     = {shift_q, rx_bit_q};
	assign target_addr = sel_s_q ? (TARGET_ADDR_BASE | STRAP_ADDR_BIT) : TARGET_ADDR_BASE;
	assign new_frame   = start_tog_q ^ start_seen_q;
	assign byte_end    = (bit_cnt_q == BIT_LAST);
	assign evt_edge    = evt_s_q ^ evt_d_q;
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = sda_oe_q;

	// strap passes two flops and is caught once settled; no config byte can override it
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			strap_m_q    <= 1'b0;
			strap_s_q    <= 1'b0;
			rst_dly_q    <= 2'h0;
			strap_lat_q  <= 1'b0;
			strap_done_q <= 1'b0;
		end
		else
		begin
			strap_m_q <= address_select_strap_in;
			strap_s_q <= strap_m_q;
			rst_dly_q <= {rst_dly_q[0], 1'b1};
			if (!strap_done_q && rst_dly_q == SYNC_DONE)
			begin
				strap_lat_q  <= strap_s_q;
				strap_done_q <= 1'b1;
			end
		end
	end

	// start: data falls while clock high; stop: data rises while clock high
	// these flops run on data edges since a stop leaves no link clock edge behind it
	always_ff @(negedge link.sda or negedge arst_n_in)
	begin
		if (!arst_n_in)
			start_tog_q <= 1'b0;
		else if (link.scl)
			start_tog_q <= ~start_tog_q;
	end

	always_ff @(posedge link.sda or negedge arst_n_in)
	begin
		if (!arst_n_in)
			stop_tog_q <= 1'b0;
		else if (link.scl)
			stop_tog_q <= ~stop_tog_q;
	end

	// latched strap is static after reset, so a plain two-flop level crossing suffices
	always_ff @(posedge link.scl or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sel_m_q  <= 1'b0;
			sel_s_q  <= 1'b0;
			rx_bit_q <= 1'b0;
		end
		else
		begin
			sel_m_q  <= strap_lat_q;
			sel_s_q  <= sel_m_q;
			rx_bit_q <= link.sda;
		end
	end

	// receive sequencer; bits are sampled on the rising edge, acted on at the falling one
	always_ff @(negedge link.scl or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_q      <= S_IDLE;
			start_seen_q <= 1'b0;
			bit_cnt_q    <= BIT_FIRST;
			shift_q      <= '0;
			ptr_q        <= '0;
			remain_q     <= '0;
			sda_oe_q     <= 1'b0;
			wr_tog_q     <= 1'b0;
		end
		else if (new_frame)
		begin
			// a repeated start also restarts the frame here
			start_seen_q <= start_tog_q;
			state_q      <= S_ADDR;
			bit_cnt_q    <= BIT_FIRST;
			sda_oe_q     <= 1'b0;
		end
		else
		begin
			case (state_q)
			S_ADDR, S_INDEX, S_COUNT, S_DATA:
			begin
				shift_q   <= rx_byte[BYTE_W-2:0];
				bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
				if (byte_end)
				begin
					case (state_q)
					S_ADDR:
					begin
						if (rx_byte[BYTE_W-1:1] == target_addr && rx_byte[0] == DIR_WRITE)
						begin
							state_q  <= S_ACK_ADDR;
							sda_oe_q <= 1'b1;
						end
						else
							state_q <= S_IGNORE;
					end
					S_INDEX:
					begin
						ptr_q    <= rx_byte[PTR_W-1:0];
						state_q  <= S_ACK_INDEX;
						sda_oe_q <= 1'b1;
					end
					S_COUNT:
					begin
						remain_q <= rx_byte;
						state_q  <= S_ACK_COUNT;
						sda_oe_q <= 1'b1;
					end
					default:
					begin
						// bytes past the count are neither stored nor acknowledged
						if (remain_q != '0)
						begin
							ptr_q    <= PTR_W'(ptr_q + 1'b1);
							remain_q <= BYTE_W'(remain_q - 1'b1);
							wr_tog_q <= ~wr_tog_q;
							state_q  <= S_ACK_DATA;
							sda_oe_q <= 1'b1;
						end
						else
							state_q <= S_IGNORE;
					end
					endcase
				end
			end
			S_ACK_ADDR, S_ACK_INDEX, S_ACK_COUNT, S_ACK_DATA:
			begin
				sda_oe_q <= 1'b0;
				state_q  <= (state_q == S_ACK_ADDR) ? S_INDEX : ((state_q == S_ACK_INDEX) ? S_COUNT : S_DATA);
			end
			default:
			begin
				state_q  <= S_IDLE;
				sda_oe_q <= 1'b0;
			end
			endcase
		end
	end

	// config array; byte 3 powers up at the medium edge rate
	always_ff @(negedge link.scl or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			for (int i = 0; i < CFG_DEPTH; i++)
				cfg_mem[i] <= (PTR_W'(i) == REF_CFG_IDX) ? REF_CFG_RESET : CFG_RESET;
		end
		else if (!new_frame && state_q == S_DATA && byte_end && remain_q != '0)
			cfg_mem[ptr_q] <= rx_byte;
	end

	// write, start and stop toggles cross as bits 0, 1 and 2
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			evt_m_q <= 3'h0;
			evt_s_q <= 3'h0;
			evt_d_q <= 3'h0;
		end
		else
		begin
			evt_m_q <= {stop_tog_q, start_tog_q, wr_tog_q};
			evt_s_q <= evt_m_q;
			evt_d_q <= evt_s_q;
		end
	end

	// the array word is stable by the time the toggle lands: the next write is a byte away
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ref_cfg_out       <= REF_CFG_RESET;
			ref_edge_rate_out <= REF_CFG_RESET[RATE_MSB:RATE_LSB];
			cfg_write_out     <= 1'b0;
		end
		else
		begin
			cfg_write_out <= evt_edge[0];
			if (evt_edge[0])
			begin
				ref_cfg_out       <= cfg_mem[REF_CFG_IDX];
				ref_edge_rate_out <= cfg_mem[REF_CFG_IDX][RATE_MSB:RATE_LSB];
			end
		end
	end

	// busy from start until stop; a start in the same cycle wins
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			busy_out <= 1'b0;
		else if (evt_edge[1])
			busy_out <= 1'b1;
		else if (evt_edge[2])
			busy_out <= 1'b0;
	end
endmodule
`default_nettype wire

// file: smbus_blk_pkg.sv
// shared constants for the indexed block write link: widths, config defaults, timing
// assumes a 50 MHz system clock on both ends and an open-drain two-wire link
// Operation
// - host starts, sends address, write; device acknowledges
// - index byte acknowledged, loaded as write pointer
// - byte count sent by host, acknowledged by device
// - data bytes stored from N through N+X-1
// - device acknowledges every one of X bytes
// - host stops after last acknowledge; device idles
// - target address taken from latched strap pin
// - config byte 3 upper bits set edge rate
package smbus_blk_pkg;
	localparam int          BYTE_W        = 8;
	localparam int          ADDR_W        = 7;
	localparam int          CFG_DEPTH     = 16;
	localparam int          PTR_W         = 4;
	localparam logic [2:0]  BIT_LAST      = 3'h7;
	localparam logic [2:0]  BIT_FIRST     = 3'h0;
	localparam logic        DIR_WRITE     = 1'h0;
	localparam logic [7:0]  CFG_RESET     = 8'h00;
	// 1F slowest, 5F, 9F, DF fastest edges; 5F after reset
	localparam logic [7:0]  REF_CFG_RESET = 8'h5F;
	localparam logic [3:0]  REF_CFG_IDX   = 4'h3;
	localparam int          RATE_MSB      = 7;
	localparam int          RATE_LSB      = 6;
	localparam logic [6:0]  STRAP_ADDR_BIT = 7'h02;
	localparam logic [1:0]  SYNC_DONE     = 2'h3;
	// host bit timing, four quarters per link clock period
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          SCL_PERIOD_NS = 10000;
	localparam int          QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [7:0]  QTR_LAST      = 8'(QUARTER_CYC - 1);
	localparam logic [7:0]  QTR_ZERO      = 8'h00;
	localparam logic [1:0]  PH_0          = 2'h0;
	localparam logic [1:0]  PH_1          = 2'h1;
	localparam logic [1:0]  PH_2          = 2'h2;
	localparam logic [1:0]  PH_3          = 2'h3;
	localparam logic [1:0]  STG_ADDR      = 2'h0;
	localparam logic [1:0]  STG_INDEX     = 2'h1;
	localparam logic [1:0]  STG_COUNT     = 2'h2;
	localparam logic [1:0]  STG_DATA      = 2'h3;
endpackage

// file: smbus_link_if.sv
// the shared two-wire link: data is a wired-AND of both ends' open-drain pulls; only the host pulls the clock
// assumes external pull-ups, so a released line reads high
`timescale 1ns/100ps
`default_nettype none
interface smbus_link_if;
	logic scl;
	logic sda;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;

	// a driving end always pulls low; released lines float high
	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

	modport device (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);
	modport host (
		input  sda,
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe
	);
endinterface
`default_nettype wire

// file: smbus_cfg_host.sv
// host end: issues one indexed block write per request, making the link clock
// assumes the user holds data_in for the next byte until data_take_out pulses
`timescale 1ns/100ps
`default_nettype none
module smbus_cfg_host (
	input  wire logic                             clk_in,
	input  wire logic                             arst_n_in,
	smbus_link_if.host                            link,
	input  wire logic                             go_in,
	input  wire logic [smbus_blk_pkg::ADDR_W-1:0] target_addr_in,
	input  wire logic [smbus_blk_pkg::BYTE_W-1:0] index_in,
	input  wire logic [smbus_blk_pkg::BYTE_W-1:0] count_in,
	input  wire logic [smbus_blk_pkg::BYTE_W-1:0] data_in,
	output var  logic                             data_take_out,
	output var  logic                             busy_out,
	output var  logic                             done_out,
	output var  logic                             nack_out
);
	import smbus_blk_pkg::*;

	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_START = 5'h02,
		H_SEND  = 5'h04,
		H_ACK   = 5'h08,
		H_STOP  = 5'h10
	} host_state_t;

	host_state_t       state_q;
	logic [7:0]        qtr_q;
	logic [1:0]        ph_q;
	logic [2:0]        bit_q;
	logic [1:0]        stage_q;
	logic [BYTE_W-1:0] tx_q;
	logic [BYTE_W-1:0] idx_q;
	logic [BYTE_W-1:0] cnt_q;
	logic [BYTE_W-1:0] remain_q;
	logic              scl_oe_q;
	logic              sda_oe_q;
	logic              sda_m_q;
	logic              sda_s_q;
	logic              tick;

	assign tick             = (qtr_q == QTR_LAST);
	assign link.host_scl_o  = 1'b0;
	assign link.host_sda_o  = 1'b0;
	assign link.host_scl_oe = scl_oe_q;
	assign link.host_sda_oe = sda_oe_q;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end
		else
		begin
			sda_m_q <= link.sda;
			sda_s_q <= sda_m_q;
		end
	end

	// quarter-period divider; the link clock is made from it
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			qtr_q <= QTR_ZERO;
			ph_q  <= PH_0;
		end
		else if (state_q == H_IDLE || tick)
		begin
			qtr_q <= QTR_ZERO;
			ph_q  <= (state_q == H_IDLE) ? PH_0 : 2'(ph_q + 2'h1);
		end
		else
			qtr_q <= 8'(qtr_q + 8'h01);
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_q       <= H_IDLE;
			bit_q         <= BIT_LAST;
			stage_q       <= STG_ADDR;
			tx_q          <= '0;
			idx_q         <= '0;
			cnt_q         <= '0;
			remain_q      <= '0;
			scl_oe_q      <= 1'b0;
			sda_oe_q      <= 1'b0;
			data_take_out <= 1'b0;
			busy_out      <= 1'b0;
			done_out      <= 1'b0;
			nack_out      <= 1'b0;
		end
		else
		begin
			data_take_out <= 1'b0;
			done_out      <= 1'b0;
			case (state_q)
			H_IDLE:
			begin
				scl_oe_q <= 1'b0;
				sda_oe_q <= 1'b0;
				if (go_in)
				begin
					tx_q     <= {target_addr_in, DIR_WRITE};
					idx_q    <= index_in;
					cnt_q    <= count_in;
					remain_q <= count_in;
					stage_q  <= STG_ADDR;
					bit_q    <= BIT_LAST;
					nack_out <= 1'b0;
					busy_out <= 1'b1;
					state_q  <= H_START;
				end
			end
			H_START:
			begin
				if (tick)
				begin
					// data falls with the clock high, then the clock goes low
					if (ph_q == PH_1)
						sda_oe_q <= 1'b1;
					if (ph_q == PH_2)
						scl_oe_q <= 1'b1;
					if (ph_q == PH_3)
						state_q <= H_SEND;
				end
			end
			H_SEND:
			begin
				if (tick)
				begin
					case (ph_q)
					PH_0:
						sda_oe_q <= ~tx_q[BYTE_W-1];
					PH_1:
						scl_oe_q <= 1'b0;
					PH_3:
					begin
						scl_oe_q <= 1'b1;
						tx_q     <= {tx_q[BYTE_W-2:0], 1'b0};
						bit_q    <= 3'(bit_q - 3'h1);
						if (bit_q == BIT_FIRST)
							state_q <= H_ACK;
					end
					default:
						scl_oe_q <= scl_oe_q;
					endcase
				end
			end
			H_ACK:
			begin
				if (tick)
				begin
					case (ph_q)
					PH_0:
						sda_oe_q <= 1'b0;
					PH_1:
						scl_oe_q <= 1'b0;
					PH_2:
						if (sda_s_q)
							nack_out <= 1'b1;
					default:
					begin
						scl_oe_q <= 1'b1;
						bit_q    <= BIT_LAST;
						if (nack_out)
							state_q <= H_STOP;
						else if (stage_q == STG_ADDR)
						begin
							tx_q    <= idx_q;
							stage_q <= STG_INDEX;
							state_q <= H_SEND;
						end
						else if (stage_q == STG_INDEX)
						begin
							tx_q    <= cnt_q;
							stage_q <= STG_COUNT;
							state_q <= H_SEND;
						end
						else if (remain_q != '0)
						begin
							tx_q          <= data_in;
							data_take_out <= 1'b1;
							remain_q      <= BYTE_W'(remain_q - 1'b1);
							stage_q       <= STG_DATA;
							state_q       <= H_SEND;
						end
						else
							state_q <= H_STOP;
					end
					endcase
				end
			end
			H_STOP:
			begin
				if (tick)
				begin
					// data rises with the clock high
					if (ph_q == PH_0)
						sda_oe_q <= 1'b1;
					if (ph_q == PH_1)
						scl_oe_q <= 1'b0;
					if (ph_q == PH_2)
						sda_oe_q <= 1'b0;
					if (ph_q == PH_3)
					begin
						busy_out <= 1'b0;
						done_out <= 1'b1;
						state_q  <= H_IDLE;
					end
				end
			end
			default:
				state_q <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: smbus_link_props.sv
// link checker: timing of start, stop and acknowledge on the shared two-wire link
// assumes both ends run on clk_in and the link lines are sampled on that clock
`timescale 1ns/100ps
`default_nettype none
module smbus_link_props (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic host_scl_oe,
	input  wire logic host_sda_oe,
	input  wire logic dev_sda_oe
);
	logic       scl_q;
	logic       sda_q;
	logic       frame_q;
	logic [3:0] bit_q;
	logic [9:0] hold_q;
	logic       start;
	logic       stop;

	assign start = scl & scl_q & sda_q & ~sda;
	assign stop  = scl & scl_q & ~sda_q & sda;

	// own copy of the line history, so start and stop detection needs no sampled-value function
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			frame_q <= 1'h0;
		else if (start)
			frame_q <= 1'h1;
		else if (stop)
			frame_q <= 1'h0;
	end

	// rising scl edges since start, nine to a byte slot
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			bit_q <= 4'h0;
		else if (start)
			bit_q <= 4'h0;
		else if (scl && !scl_q)
			bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
	end

	// saturating, so a stuck acknowledge cannot wrap back under the limit
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			hold_q <= 10'h000;
		else if (!dev_sda_oe)
			hold_q <= 10'h000;
		else if (hold_q != 10'h3FF)
			hold_q <= hold_q + 10'h001;
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);

	sequence start_seen;
		scl && scl_q && sda_q && !sda;
	endsequence
	sequence scl_drop;
		##[1:200] !scl;
	endsequence
	property start_clocks;
		start_seen |-> scl_drop;
	endproperty

	a_ack_rise_slot: assert property ($rose(dev_sda_oe) |-> !scl && bit_q == 4'h8)
		else $error("acknowledge started outside the ninth bit slot");
	a_ack_fall_slot: assert property ($fell(dev_sda_oe) |-> !scl && bit_q == 4'h0)
		else $error("acknowledge released outside the low phase after the ninth bit");
	a_ack_steady_high: assert property (scl |-> $stable(dev_sda_oe))
		else $error("target changed the data line while the clock was high");
	a_ack_length_cap: assert property (hold_q < 10'h21C)
		else $error("acknowledge held longer than one link clock period");
	a_idle_quiet: assert property (!frame_q |-> !dev_sda_oe)
		else $error("target drove the data line outside a frame");
	a_host_idle_lines: assert property (!frame_q && !start |-> !host_scl_oe && !host_sda_oe)
		else $error("host pulled a line outside a frame");
	a_start_then_clock: assert property (start_clocks)
		else $error("no clock low phase within 200 cycles of a start");
	a_sda_move_high: assert property (scl && scl_q && sda != sda_q |-> !frame_q || bit_q == 4'h1)
		else $error("data line moved during clock high outside start or stop");
endmodule
`default_nettype wire

// file: tb.sv
// bench: host end writes blocks into the target end across one shared link
// assumes package, interface, both ends and the link checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
	import smbus_blk_pkg::*;
	localparam logic [6:0] BASE_ADDR = 7'h50;
	localparam logic [6:0] DEV_ADDR  = BASE_ADDR | STRAP_ADDR_BIT;
	logic       clk_in;
	logic       arst_n_in;
	logic       strap;
	logic       go_in;
	logic [6:0] target_addr_in;
	logic [7:0] index_in;
	logic [7:0] count_in;
	logic [7:0] data_in;
	logic       data_take_out;
	logic       busy_out;
	logic       done_out;
	logic       nack_out;
	logic [1:0] ref_edge_rate_out;
	logic [7:0] ref_cfg_out;
	logic       cfg_write_out;
	logic       dev_busy;
	int         err_count;
	int         samples_checked;
	int         writes;

	smbus_link_if link_if ();

	smbus_cfg_host i_smbus_cfg_host (
		.clk_in         (clk_in),
		.arst_n_in      (arst_n_in),
		.link           (link_if),
		.go_in          (go_in),
		.target_addr_in (target_addr_in),
		.index_in       (index_in),
		.count_in       (count_in),
		.data_in        (data_in),
		.data_take_out  (data_take_out),
		.busy_out       (busy_out),
		.done_out       (done_out),
		.nack_out       (nack_out)
	);

	smbus_cfg_target #(.TARGET_ADDR_BASE(BASE_ADDR)) i_smbus_cfg_target (
		.clk_in                  (clk_in),
		.arst_n_in               (arst_n_in),
		.address_select_strap_in (strap),
		.link                    (link_if),
		.ref_edge_rate_out       (ref_edge_rate_out),
		.ref_cfg_out             (ref_cfg_out),
		.cfg_write_out           (cfg_write_out),
		.busy_out                (dev_busy)
	);

	smbus_link_props i_smbus_link_props (
		.clk_in      (clk_in),
		.arst_n_in   (arst_n_in),
		.scl         (link_if.scl),
		.sda         (link_if.sda),
		.host_scl_oe (link_if.host_scl_oe),
		.host_sda_oe (link_if.host_sda_oe),
		.dev_sda_oe  (link_if.dev_sda_oe)
	);

	initial clk_in = 1'h0;
	always #10 clk_in = ~clk_in;

	always @(posedge clk_in)
		if (cfg_write_out === 1'h1)
			writes <= writes + 1;

	task automatic test_done();
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		begin
			samples_checked++;
			if (seen !== exp)
			begin
				err_count++;
				$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	// one whole write frame; the second byte is presented once the first is taken
	task automatic frame(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] cnt,
		input logic [7:0] d0, input logic [7:0] d1);
		int n;
		begin
			writes = 0;
			n = 0;
			target_addr_in <= a;
			index_in <= idx;
			count_in <= cnt;
			data_in <= d0;
			go_in <= 1'h1;
			@(posedge clk_in);
			go_in <= 1'h0;
			while (done_out !== 1'h1 && n < 40000)
			begin
				@(posedge clk_in);
				n++;
				if (data_take_out === 1'h1)
				begin
					data_in <= d1;
					check({6'h00, busy_out, dev_busy}, 8'h03);
				end
			end
			check({7'h00, done_out}, 8'h01);
			repeat (8) @(posedge clk_in);
			check({6'h00, busy_out, dev_busy}, 8'h00);
		end
	endtask

	task automatic t_reset_state();
		begin
			check(ref_cfg_out, REF_CFG_RESET);
			check({6'h00, ref_edge_rate_out}, 8'h01);
		end
	endtask

	// index 2, two bytes: the second lands in byte 3 only if the pointer advances
	task automatic t_block_write();
		begin
			frame(DEV_ADDR, 8'h02, 8'h02, 8'hAA, 8'hDF);
			check({7'h00, nack_out}, 8'h00);
			check(writes[7:0], 8'h02);
			check(ref_cfg_out, 8'hDF);
			check({6'h00, ref_edge_rate_out}, 8'h03);
		end
	endtask

	// strap is high, so the base address alone must be ignored
	task automatic t_wrong_addr();
		begin
			frame(BASE_ADDR, 8'h03, 8'h01, 8'h9F, 8'h9F);
			check({7'h00, nack_out}, 8'h01);
			check(writes[7:0], 8'h00);
			check(ref_cfg_out, 8'hDF);
		end
	endtask

	task automatic t_single_write();
		begin
			frame(DEV_ADDR, 8'h03, 8'h01, 8'h1F, 8'h00);
			check({7'h00, nack_out}, 8'h00);
			check(writes[7:0], 8'h01);
			check(ref_cfg_out, 8'h1F);
			check({6'h00, ref_edge_rate_out}, 8'h00);
		end
	endtask

	// second reset with the strap low: the base address answers now; index 13 lands in byte 3
	task automatic t_strap_low();
		begin
			arst_n_in <= 1'h0;
			strap <= 1'h0;
			repeat (8) @(posedge clk_in);
			arst_n_in <= 1'h1;
			repeat (8) @(posedge clk_in);
			check(ref_cfg_out, REF_CFG_RESET);
			frame(BASE_ADDR, 8'h13, 8'h01, 8'h9F, 8'h00);
			check({7'h00, nack_out}, 8'h00);
			check(writes[7:0], 8'h01);
			check(ref_cfg_out, 8'h9F);
			check({6'h00, ref_edge_rate_out}, 8'h02);
		end
	endtask

	// four frames take about 67000 cycles; the limit leaves some margin
	initial
	begin
		#2000000;
		err_count++;
		test_done();
	end

	initial
	begin
		err_count = 0;
		samples_checked = 0;
		writes = 0;
		arst_n_in = 1'h0;
		strap = 1'h1;
		go_in = 1'h0;
		target_addr_in = 7'h00;
		index_in = 8'h00;
		count_in = 8'h00;
		data_in = 8'h00;
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'h1;
		repeat (8) @(posedge clk_in);
		t_reset_state();
		t_block_write();
		t_wrong_addr();
		t_single_write();
		t_strap_low();
		test_done();
	end
endmodule
`default_nettype wire
